/* File: rtl/edsd_pkg.sv */
package edsd_pkg;
  // ==========================================
  // Address map of the external data space
  localparam int edsd_addr_width = 16;
  localparam logic [15:0] edsd_periph_base = 16'h0f00;
  localparam logic [15:0] edsd_periph_last = 16'h0fff;
  localparam logic [15:0] edsd_aux_base = 16'h0800;
  localparam logic [15:0] edsd_aux_last = 16'h09ff;
  localparam logic [15:0] edsd_shared_base = 16'h0e00;
  localparam logic [15:0] edsd_shared_last = 16'h0eff;
  localparam int edsd_aux_bytes = 512;
  localparam int edsd_shared_bytes = 256;
  localparam int edsd_core_ram_bytes = 256;
  localparam int edsd_program_bytes = 65536;
  // ==========================================
  // Clocking: base crystal rate and the doubled cpu rate
  localparam int edsd_base_mhz = 12;
  localparam int edsd_double_mhz = 24;
  localparam logic [7:0] edsd_undef_read = 8'hff;
  localparam logic edsd_double_reset = 1'b0;

  typedef enum logic [1:0] {edsd_sel_none, edsd_sel_periph, edsd_sel_aux, edsd_sel_shared}
    edsd_sel_type;
endpackage

/* File: rtl/edsd_host_if.sv */
// ==========================================
// Second port of the shared ram, toward the display channel engine
interface edsd_host_if;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport owner (input wr, rd, addr, wdata, output rdata);
  modport engine (output wr, rd, addr, wdata, input rdata);
endinterface

/* File: rtl/edsd_shared_ram.sv */
module edsd_shared_ram
  import edsd_pkg::*;
#(
  parameter int depth = edsd_shared_bytes
)
(
  // Clock
  input wire logic core_clk,
  // Cpu port
  input wire logic cpu_wr,
  input wire logic [7:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  // Host port
  edsd_host_if.owner host
);
  // ==========================================
  // Storage
  logic [7:0] mem [0:depth-1];

  // The cpu and host ports index with a full byte, so the depth is fixed
  if (depth != edsd_shared_bytes)
  begin : g_depth_check
    $error("shared ram depth must be 256");
  end

  // Cpu wins any same-cycle write, and the host write is dropped even at another address; host sees the cpu data next access
  always_ff @(posedge core_clk)
  begin
    if (cpu_wr)
      mem[cpu_addr] <= cpu_wdata;
    else if (host.wr)
      mem[host.addr] <= host.wdata;
  end

  always_ff @(posedge core_clk)
  begin
    cpu_rdata <= mem[cpu_addr];
  end

  always_ff @(posedge core_clk)
  begin
    if (host.rd)
      host.rdata <= mem[host.addr];
  end
endmodule

/* File: rtl/edsd_decoder.sv */
module edsd_decoder
  import edsd_pkg::*;
#(
  parameter int aux_depth = edsd_aux_bytes
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Cpu external data bus
  input wire logic [7:0] low_addr_data_port,
  input wire logic [7:0] high_addr_port,
  input wire logic addr_latch,
  input wire logic ext_rd,
  input wire logic ext_wr,
  input wire logic [7:0] ext_wdata,
  output logic [7:0] ext_rdata,
  output logic ext_rdata_valid,
  // Peripheral register space
  output logic periph_wr,
  output logic periph_rd,
  output logic [7:0] periph_addr,
  output logic [7:0] periph_wdata,
  input wire logic [7:0] periph_rdata,
  // Display channel host port of the shared ram
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  // Cpu clock rate
  input wire logic cpu_double_rate_enable,
  output logic cpu_rate_double,
  output logic periph_clk_en_base
);
  // ==========================================
  // Address decode
  function automatic edsd_sel_type decode(input logic [15:0] a);
    if (a >= edsd_periph_base && a <= edsd_periph_last)
      return edsd_sel_periph;
    else if (a >= edsd_aux_base && a <= edsd_aux_last)
      return edsd_sel_aux;
    else if (a >= edsd_shared_base && a <= edsd_shared_last)
      return edsd_sel_shared;
    else
      return edsd_sel_none;
  endfunction

  // ==========================================
  // Elaboration checks
  // The scratch ram is indexed by the low nine address bits, so it must
  // fill its address window exactly
  if (aux_depth != int'(edsd_aux_last - edsd_aux_base) + 1)
  begin : g_aux_depth_check
    $error("scratch ram depth must match its address window");
  end

  // The core keeps its own internal ram; no region here may start inside
  // that range, so a data move can never alias it
  if (edsd_aux_base < 16'(edsd_core_ram_bytes)
      || edsd_shared_base < 16'(edsd_core_ram_bytes)
      || edsd_periph_base < 16'(edsd_core_ram_bytes))
  begin : g_core_ram_check
    $error("external regions overlap the core internal ram range");
  end

  // Code fetch never reaches this bus: the on-chip flash must span the
  // whole code space, and only data moves are decoded here
  if (edsd_program_bytes != 2 ** edsd_addr_width)
  begin : g_program_check
    $error("program flash must cover the whole code space");
  end

  logic [7:0] addr_low;
  logic [15:0] full_addr;
  edsd_sel_type sel;
  edsd_sel_type rd_sel;
  logic rd_pending;
  logic [7:0] aux_mem [0:aux_depth-1];
  logic [7:0] aux_rdata;
  logic [7:0] shared_cpu_rdata;
  logic [7:0] host_rdata_int;
  logic shared_wr;
  logic phase;

  // Low address byte is latched while the port multiplexes data
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      addr_low <= 8'h00;
    else if (addr_latch)
      addr_low <= low_addr_data_port;
  end

  assign full_addr = {high_addr_port, addr_low};
  assign sel = decode(full_addr);
  assign shared_wr = ext_wr && (sel == edsd_sel_shared);

  // ==========================================
  // Scratch ram
  always_ff @(posedge core_clk)
  begin
    if (ext_wr && sel == edsd_sel_aux)
      aux_mem[full_addr[8:0]] <= ext_wdata;
  end

  always_ff @(posedge core_clk)
  begin
    aux_rdata <= aux_mem[full_addr[8:0]];
  end

  // ==========================================
  // Shared ram
  edsd_host_if host_bus ();
  assign host_bus.wr = host_wr;
  assign host_bus.rd = host_rd;
  assign host_bus.addr = host_addr;
  assign host_bus.wdata = host_wdata;
  assign host_rdata_int = host_bus.rdata;

  edsd_shared_ram #(.depth(edsd_shared_bytes)) u_shared
  (
    .core_clk(core_clk),
    .cpu_wr(shared_wr),
    .cpu_addr(full_addr[7:0]),
    .cpu_wdata(ext_wdata),
    .cpu_rdata(shared_cpu_rdata),
    .host(host_bus)
  );

  // Host read data is registered again so the output comes from a flop
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      host_rdata <= 8'h00;
    else if (host_rd)
      host_rdata <= host_rdata_int;
  end

  // ==========================================
  // Peripheral strobes, registered
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      periph_wr <= 1'b0;
      periph_rd <= 1'b0;
      periph_addr <= 8'h00;
      periph_wdata <= 8'h00;
    end
    else
    begin
      periph_wr <= ext_wr && (sel == edsd_sel_periph);
      periph_rd <= ext_rd && (sel == edsd_sel_periph);
      periph_addr <= full_addr[7:0];
      periph_wdata <= ext_wdata;
    end
  end

  // ==========================================
  // Read return: ram data arrives one cycle after the strobe
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      rd_pending <= 1'b0;
      rd_sel <= edsd_sel_none;
    end
    else
    begin
      rd_pending <= ext_rd;
      rd_sel <= sel;
    end
  end

  // Peripheral read data is taken on the same edge as the ram data
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      ext_rdata <= 8'h00;
      ext_rdata_valid <= 1'b0;
    end
    else
    begin
      ext_rdata_valid <= rd_pending;
      if (rd_pending)
      begin
        unique case (rd_sel)
          edsd_sel_periph: ext_rdata <= periph_rdata;
          edsd_sel_aux: ext_rdata <= aux_rdata;
          edsd_sel_shared: ext_rdata <= shared_cpu_rdata;
          edsd_sel_none: ext_rdata <= edsd_undef_read;
        endcase
      end
    end
  end

  // ==========================================
  // Cpu rate; peripherals keep a base-rate enable, one pulse per two
  // core clocks in double mode so their timing does not change
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      cpu_rate_double <= edsd_double_reset;
    else
      cpu_rate_double <= cpu_double_rate_enable;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      phase <= 1'b0;
      periph_clk_en_base <= 1'b1;
    end
    else
    begin
      phase <= cpu_rate_double ? ~phase : 1'b0;
      periph_clk_en_base <= cpu_rate_double ? phase : 1'b1;
    end
  end
endmodule

/* File: sim/edsd_chk.sv */
module edsd_chk
  import edsd_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Cpu bus
  input wire logic [7:0] low_addr_data_port,
  input wire logic [7:0] high_addr_port,
  input wire logic addr_latch,
  input wire logic ext_rd,
  input wire logic ext_wr,
  input wire logic [7:0] ext_rdata,
  input wire logic ext_rdata_valid,
  // Peripheral side
  input wire logic periph_wr,
  input wire logic periph_rd,
  input wire logic [7:0] periph_addr,
  // Rate
  input wire logic cpu_double_rate_enable,
  input wire logic cpu_rate_double,
  input wire logic periph_clk_en_base
);
  logic [7:0] lo;
  logic pa;
  logic mapped;
  // Whole pages suffice: every region starts and ends on a page boundary
  assign pa = high_addr_port == 8'h0f;
  assign mapped = high_addr_port inside {8'h08, 8'h09, 8'h0e, 8'h0f};
  always_ff @(posedge core_clk or posedge reset)
    if (reset)
      lo <= 8'h00;
    else if (addr_latch)
      lo <= low_addr_data_port;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_ans;
    ##2 ext_rdata_valid;
  endsequence
  a_rd_answer: assert property (ext_rd |-> s_ans) else $error("no answer");
  a_periph_wr: assert property (ext_wr && pa |=> periph_wr && periph_addr == $past(lo))
    else $error("periph write");
  a_periph_rd: assert property (ext_rd && pa |=> periph_rd) else $error("periph read");
  a_other_wr: assert property (ext_wr && !pa |=> !periph_wr) else $error("stray write");
  a_other_rd: assert property (ext_rd && !pa |=> !periph_rd) else $error("stray read");
  a_undef_rd: assert property (ext_rd && !mapped |-> ##2 ext_rdata == edsd_undef_read)
    else $error("unmapped read");
  a_rate_copy: assert property (cpu_double_rate_enable |=> cpu_rate_double)
    else $error("rate");
  a_base_steady: assert property (!cpu_rate_double && !$past(cpu_rate_double)
    |-> periph_clk_en_base) else $error("base enable");
  a_base_toggle: assert property (cpu_rate_double && $past(cpu_rate_double)
    |-> periph_clk_en_base != $past(periph_clk_en_base)) else $error("toggle");
endmodule
bind edsd_decoder edsd_chk edsd_chk_i
(
  .core_clk(core_clk),
  .reset(reset),
  .low_addr_data_port(low_addr_data_port),
  .high_addr_port(high_addr_port),
  .addr_latch(addr_latch),
  .ext_rd(ext_rd),
  .ext_wr(ext_wr),
  .ext_rdata(ext_rdata),
  .ext_rdata_valid(ext_rdata_valid),
  .periph_wr(periph_wr),
  .periph_rd(periph_rd),
  .periph_addr(periph_addr),
  .cpu_double_rate_enable(cpu_double_rate_enable),
  .cpu_rate_double(cpu_rate_double),
  .periph_clk_en_base(periph_clk_en_base)
);

/* File: sim/edsd_cpu.sv */
module edsd_cpu (
  // Clock
  input wire logic core_clk,
  // External data bus
  output logic [7:0] low_addr_data_port,
  output logic [7:0] high_addr_port,
  output logic addr_latch,
  output logic ext_rd,
  output logic ext_wr,
  output logic [7:0] ext_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    {low_addr_data_port, high_addr_port, ext_wdata} = 24'h0;
    {addr_latch, ext_rd, ext_wr} = 3'h0;
  end
  // Released lines carry the inverse so a stale value never passes
  task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge core_clk);
    {high_addr_port, low_addr_data_port} = a;
    addr_latch = 1'b1;
    @(negedge core_clk);
    addr_latch = 1'b0;
    low_addr_data_port = ~a[7:0];
    ext_rd = !w;
    ext_wr = w;
    ext_wdata = d;
    @(negedge core_clk);
    {ext_rd, ext_wr} = 2'h0;
    high_addr_port = ~a[15:8];
    ext_wdata = ~d;
  endtask
endmodule

/* File: sim/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import edsd_pkg::*;
  logic core_clk, reset, addr_latch, ext_rd, ext_wr, ext_rdata_valid, periph_wr, periph_rd;
  logic host_wr, host_rd, cpu_double_rate_enable, cpu_rate_double, periph_clk_en_base, p;
  logic [7:0] low_addr_data_port, high_addr_port, ext_wdata, ext_rdata, periph_addr;
  logic [7:0] periph_wdata, periph_rdata, host_addr, host_wdata, host_rdata;
  int error_cnt, check_count;
  assign periph_rdata = periph_addr ^ 8'h5a;
  edsd_decoder edsd_decoder_i
  (
    .core_clk(core_clk),
    .reset(reset),
    .low_addr_data_port(low_addr_data_port),
    .high_addr_port(high_addr_port),
    .addr_latch(addr_latch),
    .ext_rd(ext_rd),
    .ext_wr(ext_wr),
    .ext_wdata(ext_wdata),
    .ext_rdata(ext_rdata),
    .ext_rdata_valid(ext_rdata_valid),
    .periph_wr(periph_wr),
    .periph_rd(periph_rd),
    .periph_addr(periph_addr),
    .periph_wdata(periph_wdata),
    .periph_rdata(periph_rdata),
    .host_wr(host_wr),
    .host_rd(host_rd),
    .host_addr(host_addr),
    .host_wdata(host_wdata),
    .host_rdata(host_rdata),
    .cpu_double_rate_enable(cpu_double_rate_enable),
    .cpu_rate_double(cpu_rate_double),
    .periph_clk_en_base(periph_clk_en_base)
  );
  edsd_cpu edsd_cpu_i
  (
    .core_clk(core_clk),
    .low_addr_data_port(low_addr_data_port),
    .high_addr_port(high_addr_port),
    .addr_latch(addr_latch),
    .ext_rd(ext_rd),
    .ext_wr(ext_wr),
    .ext_wdata(ext_wdata)
  );
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    edsd_cpu_i.acc(1'b0, a, 8'h00);
    // Valid stands for the one cycle that holds this negedge
    @(negedge core_clk);
    chk("valid", 8'h01, {7'h0, ext_rdata_valid});
    chk("rdata", e, ext_rdata);
  endtask
  task t_mem;
    edsd_cpu_i.acc(1'b1, 16'h0800, 8'ha5);
    edsd_cpu_i.acc(1'b1, 16'h09ff, 8'h3c);
    edsd_cpu_i.acc(1'b1, 16'h0e00, 8'h11);
    rd(16'h0800, 8'ha5);
    rd(16'h09ff, 8'h3c);
    @(negedge core_clk);
    {host_rd, host_addr} = 9'h100;
    repeat (2) @(negedge core_clk);
    {host_rd, host_addr} = 9'h0ff;
    chk("host_rdata", 8'h11, host_rdata);
    {host_wr, host_wdata} = 9'h177;
    @(negedge core_clk);
    host_wr = 1'b0;
    rd(16'h0eff, 8'h77);
    $display("mem end");
  endtask
  task t_periph;
    edsd_cpu_i.acc(1'b1, 16'h0f00, 8'h96);
    chk("periph_wr", 8'h01, {7'h0, periph_wr});
    chk("periph_wdata", 8'h96, periph_wdata);
    chk("periph_addr", 8'h00, periph_addr);
    rd(16'h0fff, 8'ha5);
    edsd_cpu_i.acc(1'b1, 16'h0010, 8'h5a);
    rd(16'h0010, edsd_undef_read);
    edsd_cpu_i.acc(1'b1, 16'h1800, 8'h00);
    chk("periph_wr", 8'h00, {7'h0, periph_wr});
    rd(16'h0800, 8'ha5);
    rd(16'h0a00, edsd_undef_read);
    rd(16'h1f00, edsd_undef_read);
    $display("periph end");
  endtask
  task t_rate;
    cpu_double_rate_enable = 1'b1;
    repeat (3) @(negedge core_clk);
    p = periph_clk_en_base;
    chk("cpu_rate_double", 8'h01, {7'h0, cpu_rate_double});
    @(negedge core_clk);
    chk("periph_clk_en_base", {7'h0, ~p}, {7'h0, periph_clk_en_base});
    cpu_double_rate_enable = 1'b0;
    repeat (3) @(negedge core_clk);
    chk("periph_clk_en_base", 8'h01, {7'h0, periph_clk_en_base});
    chk("cpu_rate_double", 8'h00, {7'h0, cpu_rate_double});
    $display("rate end");
  endtask
  // Mid-run reset: rate falls back to base, ram contents survive
  task t_reset;
    cpu_double_rate_enable = 1'b1;
    repeat (2) @(negedge core_clk);
    reset = 1'b1;
    @(negedge core_clk);
    chk("cpu_rate_double", 8'h00, {7'h0, cpu_rate_double});
    chk("periph_clk_en_base", 8'h01, {7'h0, periph_clk_en_base});
    cpu_double_rate_enable = 1'b0;
    reset = 1'b0;
    rd(16'h09ff, 8'h3c);
    $display("reset end");
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial
  begin
    {reset, host_wr, host_rd, cpu_double_rate_enable} = 4'h8;
    {host_addr, host_wdata} = 16'h0;
    repeat (8) @(negedge core_clk);
    reset = 1'b0;
    t_mem();
    t_periph();
    t_rate();
    t_reset();
    stop_test();
  end
  initial
  begin
    #20000;
    error_cnt++;
    stop_test();
  end
endmodule
